// File: rtl/hbi_interlock.sv
// half-bridge interlock, dead time and latched fault logic
// assumes 20 MHz sys_clk; all inputs but sys_clk and rst_b are asynchronous pins
`timescale 1ns/1ps
`include "hbi_map.svh"
module hbi_interlock (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // gate commands and fault clear from host
  input wire logic chan_a_gate_cmd,
  input wire logic chan_b_gate_cmd,
  input wire logic fault_clear_in,
  // protection inputs
  input wire hbi_pkg::hbi_drv_flt_t drv_a_flt,
  input wire hbi_pkg::hbi_drv_flt_t drv_b_flt,
  input wire logic pri_uv,
  input wire logic pri_ov,
  input wire logic over_temp,
  // switch drives
  output logic gate_a_q,
  output logic gate_b_q,
  // latched fault outputs
  output logic fault_flag_first,
  output logic fault_flag_second
);
  localparam int NIN = 10;
  localparam logic [`HBI_CNT_W-1:0] DEAD_CNT =
    `HBI_CNT_W'(`HBI_DEAD_CYC);
  logic [NIN-1:0] raw_v;
  logic [NIN-1:0] cln_v;
  logic cmd_a;
  logic cmd_b;
  logic clr;
  logic ot;
  logic uv_p;
  logic ov_p;
  hbi_pkg::hbi_drv_flt_t fa;
  hbi_pkg::hbi_drv_flt_t fb;
  hbi_pkg::hbi_state_t st_q;
  hbi_pkg::hbi_state_t st_d;
  logic [`HBI_CNT_W-1:0] cnt_q;
  logic block_a;
  logic block_b;
  logic flt1_q;
  logic flt2_q;

  // =========================================
  // input conditioning
  assign raw_v = {chan_a_gate_cmd, chan_b_gate_cmd, fault_clear_in,
                  drv_a_flt, drv_b_flt, over_temp};
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_sync
      hbi_sync u_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .raw_in(raw_v[gi]),
        .clean_q(cln_v[gi])
      );
    end
  endgenerate
  assign {cmd_a, cmd_b, clr, fa, fb, ot} = cln_v;

  // primary supply lockout passes its own pair of filters
  hbi_sync u_sync_puv (
    .sys_clk(sys_clk), .rst_b(rst_b), .raw_in(pri_uv), .clean_q(uv_p)
  );
  hbi_sync u_sync_pov (
    .sys_clk(sys_clk), .rst_b(rst_b), .raw_in(pri_ov), .clean_q(ov_p)
  );

  // =========================================
  // protection gating per channel
  // fault of one channel's driver or a primary supply fault; shared by
  // the gating and the latched flags; gating also takes ot, which sets no flag
  function automatic logic chan_fault(input hbi_pkg::hbi_drv_flt_t f,
    input logic uv, input logic ov);
    return (|f) | uv | ov;
  endfunction : chan_fault
  // temperature hysteresis lives in the sensor; level follows it
  assign block_a = ot | chan_fault(fa, uv_p, ov_p);
  assign block_b = ot | chan_fault(fb, uv_p, ov_p);

  // =========================================
  // interlock sequencer; A has priority
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      hbi_pkg::ST_IDLE: begin
        if (cmd_a) st_d = hbi_pkg::ST_DEAD_A;
        else if (cmd_b) st_d = hbi_pkg::ST_DEAD_B;
      end
      hbi_pkg::ST_DEAD_A: begin
        if (!cmd_a) st_d = hbi_pkg::ST_IDLE;
        else if (cnt_q == '0) st_d = hbi_pkg::ST_ON_A;
      end
      hbi_pkg::ST_ON_A: begin
        // B ignored while A held; no timeout
        if (!cmd_a) st_d = cmd_b ? hbi_pkg::ST_DEAD_B : hbi_pkg::ST_IDLE;
      end
      hbi_pkg::ST_DEAD_B: begin
        if (cmd_a) st_d = hbi_pkg::ST_DEAD_A;
        else if (!cmd_b) st_d = hbi_pkg::ST_IDLE;
        else if (cnt_q == '0) st_d = hbi_pkg::ST_ON_B;
      end
      hbi_pkg::ST_ON_B: begin
        if (cmd_a) st_d = hbi_pkg::ST_DEAD_A;
        else if (!cmd_b) st_d = hbi_pkg::ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (!rst_b) st_q <= hbi_pkg::ST_IDLE;
    else st_q <= st_d;
  end

  // dead-time counter reloads on entry to a dead state
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cnt_q <= '0;
    end else if (st_d != st_q) begin
      cnt_q <= DEAD_CNT - `HBI_CNT_W'(2);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - `HBI_CNT_W'(1);
    end
  end

  // gate outputs registered; protection forces off at once
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      gate_a_q <= 1'b0;
      gate_b_q <= 1'b0;
    end else begin
      gate_a_q <= (st_d == hbi_pkg::ST_ON_A) & ~block_a;
      gate_b_q <= (st_d == hbi_pkg::ST_ON_B) & ~block_b & ~cmd_a;
    end
  end

  // =========================================
  // latched fault flags; set wins over clear
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      flt1_q <= 1'b0;
      flt2_q <= 1'b0;
    end else begin
      flt1_q <= chan_fault(fa, uv_p, ov_p) | (flt1_q & ~clr);
      flt2_q <= chan_fault(fb, uv_p, ov_p) | (flt2_q & ~clr);
    end
  end
  assign fault_flag_first = flt1_q;
  assign fault_flag_second = flt2_q;

  // =========================================
  // assertions
  // one clock domain here, so clock and reset are given once
  default clocking cb_sys @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  // a rise of A restarts the dead time from any state, not only idle
  sequence s_a_start;
    $rose(cmd_a) && !block_a;
  endsequence
  // A held and unblocked through the whole dead time
  sequence s_a_held;
    (cmd_a && !block_a)[*7];
  endsequence
  // A released while B is still asked for
  sequence s_b_pend;
    st_q == hbi_pkg::ST_ON_A && !cmd_a && cmd_b && !block_b;
  endsequence
  // B held and unblocked through its dead time
  sequence s_b_held;
    (cmd_b && !cmd_a && !block_b)[*8];
  endsequence

  no_overlap_a: assert property (!(gate_a_q && gate_b_q))
    else $error("both gates on");
  b_ignore_a: assert property (cmd_a |=> !gate_b_q)
    else $error("b on while a asked");
  b_drop_a: assert property ((cmd_a && gate_b_q) |=> !gate_b_q)
    else $error("b not dropped");
  dead_a_a: assert property (
    s_a_start ##1 s_a_held |-> ##1 gate_a_q)
    else $error("a dead time wrong");
  early_a_a: assert property (s_a_start |=> !gate_a_q[*7])
    else $error("a on early");
  b_after_a_a: assert property (
    ($fell(gate_a_q) && !cmd_a && cmd_b) |-> !gate_b_q[*3])
    else $error("b on without dead time");
  b_pend_a: assert property (
    s_b_pend ##1 s_b_held |-> ##[0:1] gate_b_q)
    else $error("pending b lost");
  temp_off_a: assert property (
    ot |=> !gate_a_q && !gate_b_q)
    else $error("gate on while hot");
  oc_flag_a: assert property (
    fa.oc |=> fault_flag_first && !gate_a_q)
    else $error("oc not handled");
  oc_flag_b_a: assert property (
    fb.oc |=> fault_flag_second && !gate_b_q)
    else $error("oc b not handled");
  supply_a: assert property (
    (uv_p || ov_p) |=> fault_flag_first && fault_flag_second &&
    !gate_a_q && !gate_b_q)
    else $error("supply fault not handled");
  drv_supply_a: assert property (
    (fb.uv || fb.ov) |=> fault_flag_second && !gate_b_q)
    else $error("driver supply fault not handled");
  hold_a: assert property (
    (fault_flag_first && !clr) |=> fault_flag_first)
    else $error("fault lost");
  steady_a: assert property (
    (gate_a_q && cmd_a && !block_a) |=> gate_a_q)
    else $error("a timed out");
  release_a: assert property (
    (clr && !(|fa) && !uv_p && !ov_p) |=> !fault_flag_first)
    else $error("clear ignored");
endmodule : hbi_interlock

// File: pkg/hbi_map.svh
// constants for the half-bridge interlock and fault block
// assumes a 20 MHz system clock; included by bare name
`ifndef HBI_MAP_SVH
`define HBI_MAP_SVH
`define HBI_CLK_HZ 20000000
`define HBI_DEAD_NS 400
`define HBI_MIN_PULSE_NS 500
// least times round up to whole cycles
`define HBI_DEAD_CYC (((`HBI_DEAD_NS * (`HBI_CLK_HZ / 1000000)) + 999) / 1000)
`define HBI_PULSE_CYC (((`HBI_MIN_PULSE_NS * (`HBI_CLK_HZ / 1000000)) + 999) / 1000)
`define HBI_CNT_W 8
// fault vector bit positions
`define HBI_FB_OC 0
`define HBI_FB_UV 1
`define HBI_FB_OV 2
`endif

// File: pkg/hbi_pkg.sv
// types shared by the half-bridge interlock and fault block
// assumes nothing beyond a SystemVerilog compiler
package hbi_pkg;
  // per-driver protection inputs
  typedef struct packed {
    logic ov;
    logic uv;
    logic oc;
  } hbi_drv_flt_t;
  // interlock sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_DEAD_A, ST_ON_A, ST_DEAD_B, ST_ON_B
  } hbi_state_t;
endpackage : hbi_pkg

// File: rtl/hbi_sync.sv
// input conditioner: three-flop synchroniser with agreement filter
// assumes the input is asynchronous to sys_clk
`timescale 1ns/1ps
module hbi_sync (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // raw and conditioned level
  input wire logic raw_in,
  output logic clean_q
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  // =========================================
  // synchroniser chain; s1 is read only by s2
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= raw_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // change counts once second and third agree
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      clean_q <= 1'b0;
    end else if (s2_q == s3_q) begin
      clean_q <= s3_q;
    end
  end
endmodule : hbi_sync

// File: bench/hbi_host_model.sv
// host model: drives gate commands and fault clear toward the block
// assumes the same sys_clk as the block; levels change 1 ns after an edge
`timescale 1ns/1ps
module hbi_host_model (
  // clock
  input wire logic sys_clk,
  // commands to the block
  output logic chan_a_gate_cmd,
  output logic chan_b_gate_cmd,
  output logic fault_clear_in
);
  int edge_cnt = 0;
  int mark = 0;
  // ==========================================
  // free edge count; only this process writes it
  always @(posedge sys_clk) begin
    edge_cnt <= edge_cnt + 1;
  end
  initial begin
    chan_a_gate_cmd = 1'b0;
    chan_b_gate_cmd = 1'b0;
    fault_clear_in = 1'b0;
  end
  // each level held 40 cycles or more: 2 us, slower than 250 kHz
  // a change always lands 1 ns after an edge, like the rest of the bench
  task automatic set(input logic a, input logic b, input logic clr);
    @(posedge sys_clk);
    #1;
    while (edge_cnt - mark < 40) begin
      @(posedge sys_clk);
      #1;
    end
    chan_a_gate_cmd = a;
    chan_b_gate_cmd = b;
    fault_clear_in = clr;
    mark = edge_cnt;
  endtask : set
endmodule : hbi_host_model

// File: bench/tb.sv
// testbench for the interlock: priority, dead time, faults
// assumes hbi_pkg compiled first and the host model beside it
`timescale 1ns/1ps
module tb;
  logic sys_clk, rst_b, pri_uv, pri_ov, over_temp;
  logic cmd_a, cmd_b, clr, gate_a_q, gate_b_q, ff1, ff2;
  hbi_pkg::hbi_drv_flt_t fa, fb;
  int num_errors = 0;
  int cmp_count = 0;
  hbi_host_model i_hbi_host_model (.sys_clk(sys_clk),
    .chan_a_gate_cmd(cmd_a), .chan_b_gate_cmd(cmd_b),
    .fault_clear_in(clr));
  hbi_interlock i_hbi_interlock (.sys_clk(sys_clk), .rst_b(rst_b),
    .chan_a_gate_cmd(cmd_a), .chan_b_gate_cmd(cmd_b),
    .fault_clear_in(clr), .drv_a_flt(fa), .drv_b_flt(fb),
    .pri_uv(pri_uv), .pri_ov(pri_ov), .over_temp(over_temp),
    .gate_a_q(gate_a_q), .gate_b_q(gate_b_q),
    .fault_flag_first(ff1), .fault_flag_second(ff2));
  // ==========================================
  // clock and helpers
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic chk(input logic got, input logic exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  task automatic results;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  // ==========================================
  // scenarios; turn-on and clear checks leave one cycle of slack or more, turn-off and fault-set checks none, save a not off for b
  task automatic t_prio;
    i_hbi_host_model.set(1'b0, 1'b1, 1'b0);
    cyc(13);
    chk(gate_b_q, 1'b1, "b alone not on");
    i_hbi_host_model.set(1'b1, 1'b1, 1'b0);
    cyc(5);
    chk(gate_b_q, 1'b0, "b not dropped");
    chk(gate_a_q, 1'b0, "a early");
    cyc(8);
    chk(gate_a_q, 1'b1, "a late");
    cyc(200);
    chk(gate_a_q, 1'b1, "a timed out");
    chk(gate_b_q, 1'b0, "b overlap");
  endtask : t_prio
  task automatic t_release;
    i_hbi_host_model.set(1'b0, 1'b1, 1'b0);
    cyc(5);
    chk(gate_b_q, 1'b0, "b no dead time");
    chk(gate_a_q, 1'b0, "a not off");
    cyc(8);
    chk(gate_b_q, 1'b1, "pending b lost");
  endtask : t_release
  // overcurrent latch, clear refused while cause stays
  task automatic t_oc;
    i_hbi_host_model.set(1'b1, 1'b0, 1'b0);
    cyc(14);
    fa.oc = 1'b1;
    fb.oc = 1'b1;
    cyc(5);
    chk(gate_a_q, 1'b0, "oc gate on");
    chk(ff1, 1'b1, "oc flag a");
    fa.oc = 1'b0;
    cyc(30);
    chk(ff1, 1'b1, "flag not held");
    i_hbi_host_model.set(1'b1, 1'b0, 1'b1);
    cyc(6);
    chk(ff1, 1'b0, "clear ignored");
    chk(ff2, 1'b1, "clear with cause");
    fb.oc = 1'b0;
    i_hbi_host_model.set(1'b1, 1'b0, 1'b0);
  endtask : t_oc
  // supply faults on primary, then overtemperature
  task automatic t_supply;
    for (int i = 0; i < 2; i++) begin
      i_hbi_host_model.set(1'b1, 1'b0, 1'b0);
      cyc(14);
      {pri_ov, pri_uv} = (i == 0) ? 2'b01 : 2'b10;
      cyc(5);
      chk(gate_a_q, 1'b0, "supply gate on");
      chk(ff1 & ff2, 1'b1, "supply flags");
      {pri_ov, pri_uv} = 2'b00;
      i_hbi_host_model.set(1'b1, 1'b0, 1'b1);
    end
    i_hbi_host_model.set(1'b1, 1'b0, 1'b0);
    cyc(14);
    over_temp = 1'b1;
    cyc(5);
    chk(gate_a_q, 1'b0, "hot gate on");
    over_temp = 1'b0;
    cyc(14);
    chk(gate_a_q, 1'b1, "no resume");
  endtask : t_supply
  // isolated-side supply fault on driver B, then heat while B conducts
  task automatic t_drv;
    i_hbi_host_model.set(1'b0, 1'b1, 1'b0);
    cyc(14);
    chk(gate_a_q, 1'b0, "a not off for b");
    chk(gate_b_q, 1'b1, "b not on after a");
    fb.uv = 1'b1;
    cyc(5);
    chk(gate_b_q, 1'b0, "uv gate on");
    chk(ff2, 1'b1, "uv flag b");
    chk(ff1, 1'b0, "uv flag on a");
    fb.uv = 1'b0;
    i_hbi_host_model.set(1'b0, 1'b1, 1'b1);
    cyc(10);
    chk(ff2, 1'b0, "uv not released");
    over_temp = 1'b1;
    cyc(5);
    chk(gate_b_q, 1'b0, "hot b on");
    over_temp = 1'b0;
    cyc(14);
    chk(gate_b_q, 1'b1, "b no resume");
  endtask : t_drv
  // ==========================================
  // main sequence and watchdog
  initial begin
    rst_b = 1'b0;
    {pri_uv, pri_ov, over_temp} = 3'b000;
    fa = '0;
    fb = '0;
    cyc(10);
    chk(gate_a_q | gate_b_q | ff1 | ff2, 1'b0, "reset outputs");
    rst_b = 1'b1;
    cyc(4);
    t_prio();
    t_release();
    t_oc();
    t_supply();
    t_drv();
    results();
  end
  // the run needs about 735 cycles; 2000 leaves ample room
  initial begin
    #(2000 * 50);
    num_errors++;
    results();
  end
endmodule : tb
